// *** pkg/sttlc_defs.svh ***
// constants for the serdes transmit lane level control bank
`ifndef STTLC_DEFS_SVH
`define STTLC_DEFS_SVH
`define STTLC_SERDES 16
`define STTLC_LANES 64
`define STTLC_FLD_W 21
`define STTLC_AW 8
// register offsets (byte addresses)
`define STTLC_CTL_BASE 8'h00
`define STTLC_LVL_BASE 8'h40
`define STTLC_CFG_ADDR 8'h80
`define STTLC_BANK 7:6
`define STTLC_IDX 5:2
`define STTLC_BANK_CTL 2'h0
`define STTLC_BANK_LVL 2'h1
// per-lane field positions
`define STTLC_FSL1 4:0
`define STTLC_FDE1 7:5
`define STTLC_FSL2L 12:8
`define STTLC_FDE2L 15:13
`define STTLC_FSL2H 20:16
// per-lane field defaults
`define STTLC_FSL1_DEF 5'h11
`define STTLC_FDE1_DEF 3'h4
`define STTLC_FSL2L_DEF 5'h17
`define STTLC_FDE2L_DEF 3'h4
`define STTLC_FSL2H_DEF 5'h13
// serdes control register fields
`define STTLC_CTL_W 6
`define STTLC_CTL_MASK 3:0
`define STTLC_CTL_RLANE 5:4
`define STTLC_CTL_DEF 6'h0f
// port configuration register fields
`define STTLC_CFG_W 3
`define STTLC_CFG_LSE 0
`define STTLC_CFG_SDE 1
`define STTLC_CFG_RATE2 2
`define STTLC_CFG_DEF 3'h2
// bus responses
`define STTLC_OKAY 2'h0
`define STTLC_SLVERR 2'h2
`endif

// *** pkg/sttlc_pkg.sv ***
// types for the serdes transmit lane level control bank
`default_nettype none
`include "sttlc_defs.svh"
package sttlc_pkg;
  // complete state of the bank
  typedef struct packed {
    logic [`STTLC_LANES-1:0][`STTLC_FLD_W-1:0] lanes;
    logic [`STTLC_SERDES-1:0][`STTLC_CTL_W-1:0] ctl;
    logic [`STTLC_CFG_W-1:0] cfg;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [`STTLC_LANES-1:0][4:0] lvl;
    logic [`STTLC_LANES-1:0][2:0] fde;
    logic [`STTLC_LANES-1:0] den;
  } sttlc_state_type;
endpackage
`default_nettype wire

// *** rtl/sttlc_level_bank.sv ***
// serdes transmit lane level control bank with axi4-lite access
// Behaviour
// - bits 4:0 rate1 full-swing level, default 0x11
// - bits 7:5 rate1 fine de-emphasis, default 0x4
// - bits 12:8 rate2 -3.5dB level, default 0x17
// - bits 15:13 rate2 -3.5dB fine de-emphasis, default 0x4
// - bits 20:16 rate2 -6.0dB level, default 0x13
// - writes touch only lanes in lane select mask
// - fields sticky for all lanes across ordinary resets
// - fine de-emphasis ignored in low-swing mode
// - level code selects pre-de-emphasis swing
// - low-swing when low_swing_enable is one
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sttlc_level_bank
  import sttlc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sticky_rstn,
  input wire logic [`STTLC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`STTLC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [`STTLC_LANES-1:0][4:0] lane_drive_level,
  output logic [`STTLC_LANES-1:0][2:0] lane_fine_deemph,
  output logic [`STTLC_LANES-1:0] lane_deemph_enable
);

  sttlc_state_type st_r; // registered state
  sttlc_state_type st_nxt; // next state
  logic wr_go; // write address and data taken together
  logic rd_go; // read address taken
  logic [31:0] bmask; // byte lane mask from write strobes

  // one write and one read at a time; both write channels taken at once
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
  assign rd_go = s_axi_arvalid && !st_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign lane_drive_level = st_r.lvl;
  assign lane_fine_deemph = st_r.fde;
  assign lane_deemph_enable = st_r.den;
  assign bmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // next state: resets, register writes, reads and driver settings
  always_comb
  begin
    logic [3:0] widx; // serdes addressed by a write
    logic [3:0] ridx; // serdes addressed by a read
    logic [5:0] ln; // flat lane number
    logic low_swing_enable; // port in low-swing mode
    logic [`STTLC_FLD_W-1:0] cur; // lane field word
    widx = s_axi_awaddr[`STTLC_IDX];
    ridx = s_axi_araddr[`STTLC_IDX];
    ln = 6'h00;
    low_swing_enable = 1'b0;
    cur = '0;
    st_nxt = st_r;
    // sticky fields only reloaded with their defaults by the sticky reset
    if (!sticky_rstn)
    begin
      for (int l = 0; l < `STTLC_LANES; l++)
      begin
        st_nxt.lanes[l] = {`STTLC_FSL2H_DEF, `STTLC_FDE2L_DEF,
          `STTLC_FSL2L_DEF, `STTLC_FDE1_DEF, `STTLC_FSL1_DEF};
      end
    end
    if (!aresetn)
    begin
      // ordinary reset leaves lane fields alone
      for (int s = 0; s < `STTLC_SERDES; s++)
      begin
        st_nxt.ctl[s] = `STTLC_CTL_DEF;
      end
      st_nxt.cfg = `STTLC_CFG_DEF;
      st_nxt.bvalid = 1'b0;
      st_nxt.bresp = `STTLC_OKAY;
      st_nxt.rvalid = 1'b0;
      st_nxt.rresp = `STTLC_OKAY;
      st_nxt.rdata = 32'h0000_0000;
    end
    else
    begin
      // write response retires on bready
      if (st_r.bvalid && s_axi_bready)
      begin
        st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready)
      begin
        st_nxt.rvalid = 1'b0;
      end
      // write decode
      if (wr_go)
      begin
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp = `STTLC_OKAY;
        if (s_axi_awaddr[1:0] != 2'h0)
        begin
          st_nxt.bresp = `STTLC_SLVERR;
        end
        else if (s_axi_awaddr[`STTLC_BANK] == `STTLC_BANK_CTL)
        begin
          st_nxt.ctl[widx] = (st_r.ctl[widx] & ~bmask[`STTLC_CTL_W-1:0])
            | (s_axi_wdata[`STTLC_CTL_W-1:0] & bmask[`STTLC_CTL_W-1:0]);
        end
        else if (s_axi_awaddr[`STTLC_BANK] == `STTLC_BANK_LVL)
        begin
          // only lanes in the mask take the new value
          for (int l = 0; l < 4; l++)
          begin
            ln = {widx, l[1:0]};
            if (st_r.ctl[widx][l])
            begin
              st_nxt.lanes[ln] = (st_r.lanes[ln]
                & ~bmask[`STTLC_FLD_W-1:0])
                | (s_axi_wdata[`STTLC_FLD_W-1:0]
                & bmask[`STTLC_FLD_W-1:0]);
            end
          end
        end
        else if (s_axi_awaddr == `STTLC_CFG_ADDR)
        begin
          st_nxt.cfg = (st_r.cfg & ~bmask[`STTLC_CFG_W-1:0])
            | (s_axi_wdata[`STTLC_CFG_W-1:0] & bmask[`STTLC_CFG_W-1:0]);
        end
        else
        begin
          st_nxt.bresp = `STTLC_SLVERR;
        end
      end
      // read decode
      if (rd_go)
      begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rresp = `STTLC_OKAY;
        st_nxt.rdata = 32'h0000_0000;
        if (s_axi_araddr[1:0] != 2'h0)
        begin
          st_nxt.rresp = `STTLC_SLVERR;
        end
        else if (s_axi_araddr[`STTLC_BANK] == `STTLC_BANK_CTL)
        begin
          st_nxt.rdata[`STTLC_CTL_W-1:0] = st_r.ctl[ridx];
        end
        else if (s_axi_araddr[`STTLC_BANK] == `STTLC_BANK_LVL)
        begin
          // return the copy of the lane picked for reading
          ln = {ridx, st_r.ctl[ridx][`STTLC_CTL_RLANE]};
          st_nxt.rdata[`STTLC_FLD_W-1:0] = st_r.lanes[ln];
        end
        else if (s_axi_araddr == `STTLC_CFG_ADDR)
        begin
          st_nxt.rdata[`STTLC_CFG_W-1:0] = st_r.cfg;
        end
        else
        begin
          st_nxt.rresp = `STTLC_SLVERR;
        end
      end
    end
    // driver settings per lane from mode, rate and de-emphasis select
    low_swing_enable = st_r.cfg[`STTLC_CFG_LSE];
    for (int l = 0; l < `STTLC_LANES; l++)
    begin
      cur = st_r.lanes[l];
      if (!st_r.cfg[`STTLC_CFG_RATE2])
      begin
        st_nxt.lvl[l] = cur[`STTLC_FSL1];
        st_nxt.fde[l] = cur[`STTLC_FDE1];
      end
      else if (st_r.cfg[`STTLC_CFG_SDE])
      begin
        st_nxt.lvl[l] = cur[`STTLC_FSL2L];
        st_nxt.fde[l] = cur[`STTLC_FDE2L];
      end
      else
      begin
        st_nxt.lvl[l] = cur[`STTLC_FSL2H];
        st_nxt.fde[l] = 3'h0;
      end
      // de-emphasis off in low-swing mode
      if (low_swing_enable)
      begin
        st_nxt.fde[l] = 3'h0;
      end
      st_nxt.den[l] = !low_swing_enable;
    end
  end

  // state register; resets handled synchronously above
  always_ff @(posedge aclk)
  begin
    st_r <= st_nxt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !sticky_rstn);

  property p_rate1_level;
    !st_r.cfg[`STTLC_CFG_LSE] && !st_r.cfg[`STTLC_CFG_RATE2]
      |=> lane_drive_level[0] == $past(st_r.lanes[0][`STTLC_FSL1]);
  endproperty
  a_rate1_level: assert property (p_rate1_level)
    else $error("rate1 level not driven");

  property p_rate1_fine;
    !st_r.cfg[`STTLC_CFG_LSE] && !st_r.cfg[`STTLC_CFG_RATE2]
      |=> lane_fine_deemph[5] == $past(st_r.lanes[5][`STTLC_FDE1]);
  endproperty
  a_rate1_fine: assert property (p_rate1_fine)
    else $error("rate1 fine de-emphasis not driven");

  property p_rate2_low_level;
    st_r.cfg[`STTLC_CFG_RATE2] && st_r.cfg[`STTLC_CFG_SDE]
      |=> lane_drive_level[9] == $past(st_r.lanes[9][`STTLC_FSL2L]);
  endproperty
  a_rate2_low_level: assert property (p_rate2_low_level)
    else $error("rate2 -3.5dB level not driven");

  property p_rate2_low_fine;
    st_r.cfg[`STTLC_CFG_RATE2] && st_r.cfg[`STTLC_CFG_SDE]
      && !st_r.cfg[`STTLC_CFG_LSE]
      |=> lane_fine_deemph[9] == $past(st_r.lanes[9][`STTLC_FDE2L]);
  endproperty
  a_rate2_low_fine: assert property (p_rate2_low_fine)
    else $error("rate2 fine de-emphasis not driven");

  property p_rate2_high_level;
    st_r.cfg[`STTLC_CFG_RATE2] && !st_r.cfg[`STTLC_CFG_SDE]
      |=> lane_drive_level[63] == $past(st_r.lanes[63][`STTLC_FSL2H]);
  endproperty
  a_rate2_high_level: assert property (p_rate2_high_level)
    else $error("rate2 -6.0dB level not driven");

  property p_unselected_kept;
    wr_go && s_axi_awaddr == `STTLC_LVL_BASE && !st_r.ctl[0][0]
      |=> $stable(st_r.lanes[0]);
  endproperty
  a_unselected_kept: assert property (p_unselected_kept)
    else $error("unselected lane changed");

  property p_sticky_hold;
    @(posedge aclk) disable iff (!sticky_rstn)
      !aresetn |=> $stable(st_r.lanes);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("lane field lost in ordinary reset");

  property p_low_swing_off;
    st_r.cfg[`STTLC_CFG_LSE]
      |=> !lane_deemph_enable[3] && lane_fine_deemph[3] == 3'h0;
  endproperty
  a_low_swing_off: assert property (p_low_swing_off)
    else $error("de-emphasis active in low-swing mode");

  property p_read_lane;
    rd_go && s_axi_araddr == `STTLC_LVL_BASE
      |=> s_axi_rvalid && s_axi_rdata[`STTLC_FLD_W-1:0]
        == $past(st_r.lanes[{4'h0, st_r.ctl[0][`STTLC_CTL_RLANE]}]);
  endproperty
  a_read_lane: assert property (p_read_lane)
    else $error("read returned wrong lane copy");

  c_write_lvl: cover property (wr_go && s_axi_awaddr == `STTLC_LVL_BASE);
  c_read_lvl: cover property (rd_go && s_axi_araddr == `STTLC_LVL_BASE);
  c_low_swing: cover property (st_r.cfg[`STTLC_CFG_LSE]);
  c_rate2_high: cover property (st_r.cfg[`STTLC_CFG_RATE2]
    && !st_r.cfg[`STTLC_CFG_SDE]);

endmodule // sttlc_level_bank
`default_nettype wire

// *** tb/sttlc_level_bank_test.sv ***
// self-checking bench for the serdes transmit lane level control bank
`include "sttlc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sttlc_level_bank_test;
  import sttlc_pkg::*;
  logic aclk;
  logic aresetn;
  logic sticky_rstn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [`STTLC_LANES-1:0][4:0] lvl;
  logic [`STTLC_LANES-1:0][2:0] fde;
  logic [`STTLC_LANES-1:0] den;
  int n_fail;
  int samples_checked;
  // device under test, every strobe enabled
  sttlc_level_bank u_sttlc_level_bank (.aclk(aclk), .aresetn(aresetn),
    .sticky_rstn(sticky_rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lane_drive_level(lvl),
    .lane_fine_deemph(fde), .lane_deemph_enable(den));
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one axi4-lite write, response code compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge aclk);
    while (awready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // one axi4-lite read, data and response compared
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // lane driver outputs, sampled away from the edge
  // returns on a rising edge so the next request starts edge aligned
  task automatic lchk(input int l, input logic [8:0] e);
    @(negedge aclk);
    chk("lane", {23'h0, lvl[l], fde[l], den[l]}, {23'h0, e});
    @(posedge aclk);
  endtask
  // reset values of serdes 0 and 15 level reads, serdes 0 control, config, lanes 0 and 63
  task automatic t_defaults;
    rchk(8'h40, 32'h0013_9791, 2'h0);
    rchk(8'h7c, 32'h0013_9791, 2'h0);
    rchk(8'h00, 32'h0000_000f, 2'h0);
    rchk(8'h80, 32'h0000_0002, 2'h0);
    lchk(0, {5'h11, 3'h4, 1'b1});
    lchk(63, {5'h11, 3'h4, 1'b1});
  endtask
  // masked write reaches only the selected lanes
  task automatic t_mask;
    wr(8'h04, 32'h0000_0005, 2'h0);
    wr(8'h44, 32'hffe7_6b2a, 2'h0);
    rchk(8'h44, 32'h0007_6b2a, 2'h0);
    wr(8'h04, 32'h0000_0015, 2'h0);
    rchk(8'h44, 32'h0013_9791, 2'h0);
    wr(8'h04, 32'h0000_0000, 2'h0);
    wr(8'h44, 32'h0000_0000, 2'h0);
    rchk(8'h44, 32'h0007_6b2a, 2'h0);
    lchk(4, {5'h0a, 3'h1, 1'b1});
    lchk(5, {5'h11, 3'h4, 1'b1});
    lchk(6, {5'h0a, 3'h1, 1'b1});
    // serdes 0 with lane 0 left out of the mask
    wr(8'h00, 32'h0000_000e, 2'h0);
    wr(8'h40, 32'h0000_0000, 2'h0);
    rchk(8'h40, 32'h0013_9791, 2'h0);
    lchk(1, {5'h00, 3'h0, 1'b1});
    lchk(0, {5'h11, 3'h4, 1'b1});
  endtask
  // rate, de-emphasis selection and swing mode choose the fields
  task automatic t_modes;
    logic [2:0] cf [0:5];
    logic [8:0] ex [0:5];
    cf = '{3'h6, 3'h4, 3'h5, 3'h7, 3'h1, 3'h0};
    ex = '{{5'h0b, 3'h3, 1'b1}, {5'h07, 3'h0, 1'b1},
      {5'h07, 3'h0, 1'b0}, {5'h0b, 3'h0, 1'b0},
      {5'h0a, 3'h0, 1'b0}, {5'h0a, 3'h1, 1'b1}};
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h80, {29'h0, cf[i]}, 2'h0);
      rchk(8'h80, {29'h0, cf[i]}, 2'h0);
      lchk(4, ex[i]);
    end
    wr(8'h80, 32'h0000_0006, 2'h0);
    lchk(5, {5'h17, 3'h4, 1'b1});
  endtask
  // ordinary reset keeps lane fields, sticky reset restores them
  task automatic t_sticky;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(8'h44, 32'h0007_6b2a, 2'h0);
    rchk(8'h04, 32'h0000_000f, 2'h0);
    lchk(4, {5'h0a, 3'h1, 1'b1});
    sticky_rstn <= 1'b0;
    repeat (2) @(posedge aclk);
    sticky_rstn <= 1'b1;
    @(posedge aclk);
    rchk(8'h44, 32'h0013_9791, 2'h0);
  endtask
  // unmapped and misaligned places are refused
  task automatic t_unmapped;
    rchk(8'hc0, 32'h0, 2'h2);
    wr(8'hc0, 32'h0000_0001, 2'h2);
    wr(8'h45, 32'h0000_0000, 2'h2);
    rchk(8'h44, 32'h0013_9791, 2'h0);
  endtask
  // 100 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // watchdog far beyond the expected run
  initial
  begin
    #400000;
    n_fail++;
    give_verdict;
  end
  // main sequence
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    sticky_rstn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sticky_rstn <= 1'b1;
    @(posedge aclk);
    t_defaults;
    t_mask;
    t_modes;
    t_sticky;
    t_unmapped;
    give_verdict;
  end
endmodule // sttlc_level_bank_test
`default_nettype wire
